//--- common/lamp_pkg.sv
// Package: constants and carrier types for the standstill monitor lamp logic
package lamp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned BLINK_CNT_W   = 24;
  localparam logic [BLINK_CNT_W-1:0] BLINK_CNT_RST = 24'h000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_ALERT = 2'b01,
    MODE_LATCH = 2'b10
  } mode_t;

  typedef enum logic [2:0] {
    ERR_NONE   = 3'b000,
    ERR_CONFIG = 3'b001,
    ERR_GEN    = 3'b010,
    ERR_SUPPLY = 3'b011,
    ERR_OUT    = 3'b100,
    ERR_EXT    = 3'b101
  } err_t;

  typedef struct packed {
    logic below_thr;     // Phase voltage below selected threshold
    logic delay_done;    // Activation delay fully elapsed
    logic wire_break;    // Broken wire on this channel
  } chan_in_t;

  typedef struct packed {
    logic gen_err;       // General internal error
    logic cfg_err;       // Selector moved during operation
    logic supply_err;    // Supply out of tolerance
    logic out_err;       // Own safety output error
    logic ext_err;       // Extension module output error
  } fault_in_t;

  typedef struct packed {
    logic supply_lamp;
    logic state_lamp;
    logic first_channel_lamp;
    logic second_channel_lamp;
    logic fault_lamp;
  } lamps_t;

  typedef struct packed {
    logic [BLINK_CNT_W-1:0] blink_cnt;
    logic                   blink;
    mode_t                  mode;
    err_t                   err;
    lamps_t                 lamps;
    logic                   out_on;
  } lamp_state_t;

  localparam lamps_t LAMPS_RST = 5'h00;

endpackage

//--- rtl/standstill_lamps.sv
// Lamp and safe-state logic of the motor standstill monitor
// Functional notes
// - Outside the latched error state, the output-state lamp is lit exactly while the safety output is active.
// - In run mode without bridged phase, a channel lamp is dark while its voltage is above threshold or the delay has not elapsed.
// - In run mode without bridged phase, a channel lamp is lit only when its voltage is below threshold and the delay has elapsed.
// - With a single bridged phase both channel lamps behave identically.
// - Alerts flash the fault lamp with channel lamps; errors light the fault lamp steadily.
// - Any alert forces the safe state and switches the safety output off.
// - The alert safe state is left on its own once the alert cause is gone.
// - Without bridged phase, a broken wire on one channel flashes the fault lamp and only that channel lamp.
// - Broken wires on both channels flash the fault lamp and both channel lamps together.
// - A detected error latches the safe state until power is cycled.
// - A configuration error lights output and channel lamps steadily; a general error flashes them.
// - A supply error lights the fault lamp and flashes the supply lamp.
// - An own output error lights the fault lamp and flashes the output-state lamp.
// - An extension output error lights the fault lamp and flashes both channel lamps.
`timescale 1ns/10ps
`default_nettype none

module standstill_lamps (
  input  wire logic              sys_clk,      // 50 MHz clock
  input  wire logic              rstn,         // Async reset, power-on
  input  wire lamp_pkg::chan_in_t first_chan,  // First channel comparator/delay/wire
  input  wire lamp_pkg::chan_in_t second_chan, // Second channel comparator/delay/wire
  input  wire logic              single_phase, // Outer terminals bridged
  input  wire lamp_pkg::fault_in_t faults,     // Internal fault flags
  output lamp_pkg::lamps_t       lamps,        // Lamp drives
  output logic                   safe_out_on,  // Safety-related output activated
  output logic                   error_latched // Detected error held
);
  import lamp_pkg::*;

  lamp_state_t st_r;
  lamp_state_t st_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ss1;
    logic ss2;
    logic alert;
    err_t pick;
    ss1    = 1'b0;
    ss2    = 1'b0;
    alert  = 1'b0;
    pick   = ERR_NONE;
    st_nxt = st_r;

    // Common blink generator
    if (st_r.blink_cnt == BLINK_CNT_W'(BLINK_HALF_CYC - 1)) begin
      st_nxt.blink_cnt = BLINK_CNT_RST;
      st_nxt.blink     = ~st_r.blink;
    end else begin
      st_nxt.blink_cnt = st_r.blink_cnt + 1'b1;
    end

    // Fixed error priority
    if (faults.gen_err) begin
      pick = ERR_GEN;
    end else if (faults.cfg_err) begin
      pick = ERR_CONFIG;
    end else if (faults.supply_err) begin
      pick = ERR_SUPPLY;
    end else if (faults.out_err) begin
      pick = ERR_OUT;
    end else if (faults.ext_err) begin
      pick = ERR_EXT;
    end

    ss1   = first_chan.below_thr & first_chan.delay_done;
    ss2   = second_chan.below_thr & second_chan.delay_done;
    if (single_phase) begin
      ss2 = ss1;
    end
    alert = first_chan.wire_break | (second_chan.wire_break & ~single_phase) |
            (single_phase & second_chan.wire_break);

    case (st_r.mode)
      MODE_RUN, MODE_ALERT: begin
        if (pick != ERR_NONE) begin
          st_nxt.mode = MODE_LATCH;
          st_nxt.err  = pick;
        end else if (alert) begin
          st_nxt.mode = MODE_ALERT;
        end else begin
          st_nxt.mode = MODE_RUN;
        end
      end
      MODE_LATCH: begin
        st_nxt.mode = MODE_LATCH;
      end
      default: begin
        st_nxt.mode = MODE_LATCH;
      end
    endcase

    // Output active only in run with standstill on both channels
    st_nxt.out_on = (st_nxt.mode == MODE_RUN) & ss1 & ss2;

    st_nxt.lamps.supply_lamp = 1'b1;
    st_nxt.lamps.state_lamp  = st_nxt.out_on;
    st_nxt.lamps.first_channel_lamp  = ss1;
    st_nxt.lamps.second_channel_lamp = ss2;
    st_nxt.lamps.fault_lamp  = 1'b0;

    if (st_nxt.mode == MODE_LATCH) begin
      st_nxt.lamps.fault_lamp = 1'b1;
      st_nxt.lamps.state_lamp = 1'b0;
      st_nxt.lamps.first_channel_lamp  = 1'b0;
      st_nxt.lamps.second_channel_lamp = 1'b0;
      case (st_nxt.err)
        ERR_CONFIG: begin
          st_nxt.lamps.state_lamp = 1'b1;
          st_nxt.lamps.first_channel_lamp  = 1'b1;
          st_nxt.lamps.second_channel_lamp = 1'b1;
        end
        ERR_GEN: begin
          st_nxt.lamps.state_lamp = st_nxt.blink;
          st_nxt.lamps.first_channel_lamp  = st_nxt.blink;
          st_nxt.lamps.second_channel_lamp = st_nxt.blink;
        end
        ERR_SUPPLY: begin
          st_nxt.lamps.supply_lamp = st_nxt.blink;
        end
        ERR_OUT: begin
          st_nxt.lamps.state_lamp = st_nxt.blink;
        end
        ERR_EXT: begin
          st_nxt.lamps.first_channel_lamp  = st_nxt.blink;
          st_nxt.lamps.second_channel_lamp = st_nxt.blink;
        end
        default: begin
          st_nxt.lamps.state_lamp = 1'b1;
        end
      endcase
    end else if (st_nxt.mode == MODE_ALERT) begin
      st_nxt.lamps.fault_lamp = st_nxt.blink;
      st_nxt.lamps.first_channel_lamp  = 1'b0;
      st_nxt.lamps.second_channel_lamp = 1'b0;
      if (single_phase) begin
        st_nxt.lamps.first_channel_lamp  = st_nxt.blink;
        st_nxt.lamps.second_channel_lamp = st_nxt.blink;
      end else begin
        if (first_chan.wire_break) begin
          st_nxt.lamps.first_channel_lamp  = st_nxt.blink;
        end
        if (second_chan.wire_break) begin
          st_nxt.lamps.second_channel_lamp = st_nxt.blink;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r.blink_cnt <= BLINK_CNT_RST;
      st_r.blink     <= 1'b0;
      st_r.mode      <= MODE_RUN;
      st_r.err       <= ERR_NONE;
      st_r.lamps     <= LAMPS_RST;
      st_r.out_on    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lamps         = st_r.lamps;
  assign safe_out_on   = st_r.out_on;
  assign error_latched = (st_r.mode == MODE_LATCH);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_latched;
    st_r.mode == MODE_LATCH;
  endsequence

  chk_state_lamp_out: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r.mode != MODE_LATCH) |-> (lamps.state_lamp == safe_out_on))
    else $error("state lamp differs from output");

  chk_chan_lamp_dark: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!first_chan.below_thr || !first_chan.delay_done) && !single_phase &&
    $past(st_nxt.mode) == MODE_RUN && st_nxt.mode == MODE_RUN |=> !lamps.first_channel_lamp)
    else $error("channel lamp lit without standstill");

  chk_chan_lamp_lit: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_nxt.mode == MODE_RUN) && first_chan.below_thr && first_chan.delay_done |=>
    lamps.first_channel_lamp)
    else $error("channel lamp dark at standstill");

  chk_single_same: assert property (@(posedge sys_clk) disable iff (!rstn)
    single_phase && st_nxt.mode != MODE_LATCH |=>
    lamps.first_channel_lamp == lamps.second_channel_lamp)
    else $error("bridged channel lamps differ");

  chk_alert_safe: assert property (@(posedge sys_clk) disable iff (!rstn)
    (first_chan.wire_break || second_chan.wire_break) |=> !safe_out_on)
    else $error("output active during alert");

  chk_alert_exit: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_r.mode == MODE_ALERT && !first_chan.wire_break && !second_chan.wire_break &&
    faults == 5'h00 |=> st_r.mode == MODE_RUN)
    else $error("alert state not left");

  chk_err_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_latched |=> s_latched ##1 (s_latched and !safe_out_on))
    else $error("error latch released");

  chk_fault_steady: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_latched |-> lamps.fault_lamp)
    else $error("fault lamp not steady on error");

  chk_supply_blink: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s_latched and (st_r.err == ERR_SUPPLY)) |-> lamps.supply_lamp == st_r.blink)
    else $error("supply lamp not flashing");

  chk_wire_flash: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_nxt.mode == MODE_ALERT && !single_phase && first_chan.wire_break && !second_chan.wire_break |=>
    lamps.first_channel_lamp == st_r.blink && !lamps.second_channel_lamp && lamps.fault_lamp == st_r.blink)
    else $error("broken wire lamps wrong");

  chk_ext_flash: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_r.mode == MODE_LATCH && st_r.err == ERR_EXT) |->
    lamps.first_channel_lamp == st_r.blink && lamps.second_channel_lamp == st_r.blink && !lamps.state_lamp)
    else $error("extension error lamps wrong");

  chk_blink_phase: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_r.mode == MODE_ALERT |-> lamps.fault_lamp == st_r.blink)
    else $error("flash out of phase");

endmodule

`default_nettype wire

//--- dv/sensor_model.sv
// Phase voltage sensing model: comparator, activation delay timer, wire-break flag
`timescale 1ns/10ps
`default_nettype none

module sensor_model #(
  parameter int unsigned DELAY_CYC = 16
) (
  input  wire logic              sys_clk,   // Clock
  input  wire logic              rstn,      // Async reset
  input  wire logic              volt_high, // Phase voltage above threshold
  input  wire logic              broken,    // Measurement wire open
  output var lamp_pkg::chan_in_t chan       // Channel result
);
  import lamp_pkg::*;
  logic [15:0] below_cnt_r;

  // Delay restarts whenever the voltage leaves the standstill band
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      below_cnt_r <= 16'h0000;
    end else if (volt_high || broken) begin
      below_cnt_r <= 16'h0000;
    end else if (below_cnt_r < 16'(DELAY_CYC)) begin
      below_cnt_r <= below_cnt_r + 16'h0001;
    end
  end

  assign chan.below_thr  = !volt_high && !broken;
  assign chan.delay_done = (below_cnt_r >= 16'(DELAY_CYC));
  assign chan.wire_break = broken;
endmodule

`default_nettype wire

//--- dv/standstill_lamps_tb_top.sv
// Testbench: lamp patterns, safe state and error latching of the standstill lamps
`timescale 1ns/10ps
`default_nettype none

module standstill_lamps_tb_top;
  import lamp_pkg::*;
  localparam int unsigned DLY = 16;
  logic      sys_clk, rstn, single_phase, v1_high, v2_high, brk1, brk2;
  logic      safe_out_on, error_latched;
  fault_in_t faults;
  chan_in_t  first_chan, second_chan;
  lamps_t    lamps;
  int        failures, n_checks;
  logic [4:0] err_f [7] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h18, 5'h06};
  logic [4:0] err_l [7] = '{5'h11, 5'h1f, 5'h01, 5'h11, 5'h11, 5'h11, 5'h01};

  sensor_model #(.DELAY_CYC(DLY)) i_sensor_model (.sys_clk(sys_clk), .rstn(rstn), .volt_high(v1_high),
    .broken(brk1), .chan(first_chan));
  sensor_model #(.DELAY_CYC(DLY)) i_sensor_model_2 (.sys_clk(sys_clk), .rstn(rstn), .volt_high(v2_high),
    .broken(brk2), .chan(second_chan));
  standstill_lamps i_standstill_lamps (.sys_clk(sys_clk), .rstn(rstn), .first_chan(first_chan),
    .second_chan(second_chan), .single_phase(single_phase), .faults(faults), .lamps(lamps),
    .safe_out_on(safe_out_on), .error_latched(error_latched));

  // ----------------------------------------------------------------
  // Clock, tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    // Idle running-motor inputs, so the first edge after release sees no stale fault
    {v1_high, v2_high, single_phase, brk1, brk2, faults} = {5'h18, 5'h00};
    rstn = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1'b1;
  endtask

  task automatic drive(input logic a, input logic b, input logic sp, input logic w1, input logic w2,
                       input logic [4:0] f);
    @(posedge sys_clk);
    #1;
    {v1_high, v2_high, single_phase, brk1, brk2, faults} = {a, b, sp, w1, w2, f};
  endtask

  task automatic expect_out(input int cyc, input lamps_t el, input logic eo, input logic ee, input string msg);
    repeat (cyc) @(posedge sys_clk);
    #1;
    n_checks++;
    if (lamps !== el || safe_out_on !== eo || error_latched !== ee) begin
      failures++;
      $display("Error at %0t: %s lamps %b out %b latch %b", $time, msg, lamps, safe_out_on, error_latched);
    end
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    n_checks = 0;
    do_reset();
    expect_out(2, 5'h10, 1'b0, 1'b0, "running motor");
    drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    expect_out(DLY - 2, 5'h10, 1'b0, 1'b0, "delay pending");
    expect_out(4, 5'h1e, 1'b1, 1'b0, "standstill");
    drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
    expect_out(2, 5'h14, 1'b0, 1'b0, "second above");
    drive(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 5'h00);
    expect_out(2, 5'h1e, 1'b1, 1'b0, "bridged phase");
    drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00);
    expect_out(2, 5'h10, 1'b0, 1'b0, "first wire broken");
    drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    expect_out(DLY + 3, 5'h1e, 1'b1, 1'b0, "alert left");
    drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 5'h00);
    expect_out(2, 5'h10, 1'b0, 1'b0, "both wires broken");
    $display("Status and alert test done");
    for (int i = 0; i < 7; i++) begin
      do_reset();
      drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, err_f[i]);
      expect_out(2, err_l[i], 1'b0, 1'b1, "error pattern");
      drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
      expect_out(3, err_l[i], 1'b0, 1'b1, "cause removed");
      drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 5'h1f);
      expect_out(2, err_l[i], 1'b0, 1'b1, "later errors");
    end
    $display("Error test done");
    do_reset();
    drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
    expect_out(2, 5'h10, 1'b0, 1'b0, "released by reset");
    test_done();
  end

  initial begin
    #200000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
endmodule

`default_nettype wire
